// [core/lec_pkg.sv]
// Register map, fields and constants
package lec_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_MONITOR_GAIN_CONFIG        = 10'h00c;
  localparam logic [9:0] IDX_LOSS_DETECT_CONFIG         = 10'h00d;
  localparam logic [9:0] IDX_ERROR_COUNT_INSERT_CONTROL = 10'h00e;
  localparam logic [9:0] IDX_EVENT_STATUS               = 10'h010;
  localparam logic [9:0] IDX_EVENT_MASK                 = 10'h011;
  localparam logic [9:0] IDX_ERROR_COUNT_HIGH           = 10'h012;
  localparam logic [9:0] IDX_ERROR_COUNT_LOW            = 10'h013;
  localparam logic [9:0] IDX_LINK_STATE                 = 10'h014;

  // ==========================================================================
  // Field positions
  localparam int LD_CRITERIA   = 7;
  localparam int LD_RX_THR_LSB = 4;
  localparam int LD_TX_THR_LSB = 2;
  localparam int LD_TX_PER_LSB = 0;
  localparam int EC_EXZ_RULE   = 7;
  localparam int EC_VIOL_INS   = 6;
  localparam int EC_BERR_INS   = 5;
  localparam int EC_SRC_LSB    = 2;
  localparam int EC_MODE       = 1;
  localparam int EC_LATCH      = 0;
  // Event status bits
  localparam int EV_LINE_LOSS  = 0;
  localparam int EV_TX_LOSS    = 1;
  localparam int EV_VIOL_DONE  = 2;
  localparam int EV_BERR_DONE  = 3;
  localparam int EV_LATCHED    = 4;
  localparam int EV_WIDTH      = 5;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_MONITOR_GAIN_CONFIG = 8'h00;
  localparam logic [7:0] RST_LOSS_DETECT_CONFIG  = 8'h15;
  localparam logic [7:0] RST_ERROR_COUNT_CONTROL = 8'h00;

  // ==========================================================================
  // Timing
  localparam longint ONE_SECOND_CYC  = 250_000_000; // Clocks per second
  localparam int     LOSS_CNT_W      = 12;
  localparam logic [LOSS_CNT_W-1:0] TX_PERIOD_SHORT = 12'h010;
  localparam logic [LOSS_CNT_W-1:0] TX_PERIOD_MID   = 12'h020;
  localparam logic [LOSS_CNT_W-1:0] TX_PERIOD_LONG  = 12'h040;

  // Error counter source codes
  typedef enum logic [2:0] {
    SRC_OFF, SRC_LINE_VIOL, SRC_LINE_EXZ, SRC_LINE_BOTH,
    SRC_SYS_VIOL, SRC_SYS_EXZ, SRC_SYS_BOTH, SRC_PATTERN
  } lec_src_t;

  // Gain in dB by code
  function automatic logic [7:0] gainDb(input logic [1:0] code);
    case (code)
      2'b01:   gainDb = 8'h14;
      2'b10:   gainDb = 8'h1a;
      2'b11:   gainDb = 8'h20;
      default: gainDb = 8'h00;
    endcase
  endfunction

  // Receive threshold in 10 mVpp, zero if reserved
  function automatic logic [7:0] rxThrCv(input logic [2:0] code, input logic monitor);
    logic [7:0] normalTab [8];
    logic [7:0] monTab [4];
    normalTab = '{8'h32, 8'h46, 8'h5a, 8'h78, 8'h8c, 8'ha0, 8'hb4, 8'hc8};
    monTab    = '{8'h64, 8'h8c, 8'hb4, 8'hdc};
    if (!monitor) rxThrCv = normalTab[code];
    else if (code[2]) rxThrCv = 8'h00;
    else rxThrCv = monTab[code[1:0]];
  endfunction

  // Transmit threshold in 10 mVp
  function automatic logic [7:0] txThrCv(input logic [1:0] code, input logic single);
    logic [7:0] diffTab [4];
    logic [7:0] singTab [4];
    diffTab = '{8'h78, 8'h5a, 8'h3c, 8'h28};
    singTab = '{8'h3d, 8'h30, 8'h20, 8'h18};
    txThrCv = single ? singTab[code] : diffTab[code];
  endfunction

endpackage

// [core/lec_loss_timer.sv]
// Low-interval loss timer
`timescale 1ns/1ps
`default_nettype none
module lec_loss_timer
  import lec_pkg::*;
#(
  parameter int CW = LOSS_CNT_W
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  // Interval strobe and comparator
  input  wire logic          intervalTick,
  input  wire logic          above,
  input  wire logic [CW-1:0] limit,
  // Loss state
  output logic               lost
);

  logic [CW-1:0] lowCount;
  logic [CW-1:0] next_lowCount;
  logic          next_lost;

  // Count low intervals, clear on a good pulse
  always_comb begin
    next_lowCount = lowCount;
    next_lost     = lost;
    if (intervalTick) begin
      if (above) begin
        next_lowCount = '0;
        next_lost     = 1'b0;
      end else if (lowCount < limit) begin
        next_lowCount = lowCount + 1'b1;
        if (lowCount + 1'b1 >= limit) begin
          next_lost = 1'b1;
        end
      end
    end
  end

  // State registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lowCount <= '0;
      lost     <= 1'b0;
    end else begin
      lowCount <= next_lowCount;
      lost     <= next_lost;
    end
  end

endmodule
`default_nettype wire

// [core/lec_error_counter.sv]
// Error counter with latching
`timescale 1ns/1ps
`default_nettype none
module lec_error_counter
  import lec_pkg::*;
#(
  parameter longint SEC_CYCLES = ONE_SECOND_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Control
  input  wire logic [2:0]  source,
  input  wire logic        autoMode,
  input  wire logic        manualLatch,
  // Error events, one-cycle strobes
  input  wire logic        lineViol,
  input  wire logic        lineExz,
  input  wire logic        sysViol,
  input  wire logic        sysExz,
  input  wire logic        patErr,
  // Latched count
  output logic [15:0]      heldCount,
  output logic             latched
);

  logic [15:0] runCount;
  logic [31:0] secCount;
  logic [15:0] next_runCount;
  logic [15:0] next_heldCount;
  logic [31:0] next_secCount;
  logic        next_latched;
  logic [1:0]  inc;
  logic        doLatch;
  logic [16:0] sum;

  // Events selected by the source code
  always_comb begin
    case (lec_src_t'(source))
      SRC_LINE_VIOL: inc = {1'b0, lineViol};
      SRC_LINE_EXZ:  inc = {1'b0, lineExz};
      SRC_LINE_BOTH: inc = {1'b0, lineViol} + {1'b0, lineExz};
      SRC_SYS_VIOL:  inc = {1'b0, sysViol};
      SRC_SYS_EXZ:   inc = {1'b0, sysExz};
      SRC_SYS_BOTH:  inc = {1'b0, sysViol} + {1'b0, sysExz};
      SRC_PATTERN:   inc = {1'b0, patErr};
      default:       inc = 2'b00;
    endcase
  end

  // Count with saturation, latch and restart
  always_comb begin
    next_secCount  = secCount + 32'h0000_0001;
    doLatch        = 1'b0;
    if (secCount >= 32'(SEC_CYCLES - 1)) begin
      next_secCount = '0;
      doLatch       = autoMode;
    end
    if (!autoMode && manualLatch) begin
      doLatch = 1'b1;
    end
    sum            = {1'b0, runCount} + {15'h0000, inc};
    next_runCount  = sum[16] ? 16'hffff : sum[15:0];
    next_heldCount = heldCount;
    next_latched   = doLatch;
    if (doLatch) begin
      next_heldCount = next_runCount;
      next_runCount  = '0;
    end
  end

  // State registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      runCount  <= '0;
      heldCount <= '0;
      secCount  <= '0;
      latched   <= 1'b0;
    end else begin
      runCount  <= next_runCount;
      heldCount <= next_heldCount;
      secCount  <= next_secCount;
      latched   <= next_latched;
    end
  end

endmodule
`default_nettype wire

// [core/lec_loss_error_control.sv]
// Loss and error control with APB registers
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Function
// [R1] Gain code gives 0, 20, 26 or 32 dB, 0 dB at reset.
// [R2] Criteria bit picks the first family at 0, the second at 1.
// [R3] Line loss is set after N low intervals, N by criteria.
// [R4] Normal mode codes give 0.5 to 2.0 Vpp, default 0.7.
// [R5] Monitor mode codes give 1.0 to 2.2 Vpp, default 1.4, 1xx reserved.
// [R6] Transmit loss is set after the low period and cleared by one good pulse.
// [R7] Differential transmit threshold is 1.2, 0.9, 0.6 or 0.4 Vp.
// [R8] Single-ended transmit threshold is 0.61, 0.48, 0.32 or 0.24 Vp.
// [R9] Period code gives 16, 32 (default) or 64 pulses.
// [R10] Excess-zero bit picks ANSI at 0, FCC at 1.
// [R11] A violation request marks the next mark, then clears.
// [R12] A rising bit-error bit injects one pattern error, then clears.
// [R13] Source code disables the counter or picks its events.
// [R14] Mode bit picks manual or one-second latching.
// [R15] In manual mode a rising latch bit updates the count.
// [R16] Insertion bits read one while pending.
module lec_loss_error_control
  import lec_pkg::*;
#(
  parameter int     LINE_SIGNAL_LOSS_N_STD = 128,
  parameter int     LINE_SIGNAL_LOSS_N_ALT = 256,
  parameter longint SEC_CYCLES = ONE_SECOND_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Mode pins, asynchronous
  input  wire logic        lineMonitorMode,
  input  wire logic        singleEndedTx,
  // Datapath strobes, same clock
  input  wire logic        rxIntervalTick,
  input  wire logic        rxAbove,
  input  wire logic        txIntervalTick,
  input  wire logic        txAbove,
  input  wire logic        txMarkSlot,
  input  wire logic        patternBitSlot,
  input  wire logic        line_bipolar_violation,
  input  wire logic        line_excess_zeros,
  input  wire logic        system_bipolar_violation,
  input  wire logic        system_excess_zeros,
  input  wire logic        patternError,
  // Analog and datapath controls
  output logic [1:0]       monitor_gain_sel,
  output logic [7:0]       monitorGainDb,
  output logic             loss_criteria_sel,
  output logic [7:0]       rxThresholdCv,
  output logic             rxThresholdReserved,
  output logic [7:0]       txThresholdCv,
  output logic             excess_zero_rule_sel,
  output logic             insertViolation,
  output logic             insertBitError,
  // Status
  output logic             line_signal_loss,
  output logic             transmit_signal_loss,
  output logic             irq
);

  // ==========================================================================
  // Mode pin synchronisers
  logic monSync1;
  logic monSync2;
  logic seSync1;
  logic seSync2;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      monSync1 <= 1'b0;
      monSync2 <= 1'b0;
      seSync1  <= 1'b0;
      seSync2  <= 1'b0;
    end else begin
      monSync1 <= lineMonitorMode;
      monSync2 <= monSync1;
      seSync1  <= singleEndedTx;
      seSync2  <= seSync1;
    end
  end

  // ==========================================================================
  // Register state
  logic [7:0]          gainCfg;
  logic [7:0]          lossCfg;
  logic                exzRule;
  logic                violPend;
  logic                berrPend;
  logic [2:0]          cntSrc;
  logic                cntMode;
  logic                latchReq;
  logic [EV_WIDTH-1:0] evStatus;
  logic [EV_WIDTH-1:0] evMask;
  logic                lineLossPrev;
  logic                txLossPrev;
  logic [7:0]          next_gainCfg;
  logic [7:0]          next_lossCfg;
  logic                next_exzRule;
  logic                next_violPend;
  logic                next_berrPend;
  logic [2:0]          next_cntSrc;
  logic                next_cntMode;
  logic                next_latchReq;
  logic [EV_WIDTH-1:0] next_evStatus;
  logic [EV_WIDTH-1:0] next_evMask;
  logic [31:0]         next_prdata;
  logic                next_pready;
  logic                next_pslverr;
  logic                next_insertViolation;
  logic                next_insertBitError;
  logic                next_irq;
  logic                manualLatch;
  logic                countLatched;
  logic [15:0]         heldCount;
  logic                wrDone;
  logic [9:0]          regIdx;
  logic [7:0]          wByte;
  logic                mapped;
  logic [EV_WIDTH-1:0] evSet;
  logic [LOSS_CNT_W-1:0] rxLimit;
  logic [LOSS_CNT_W-1:0] txLimit;

  assign regIdx = paddr[11:2];
  assign wByte  = pwdata[7:0];
  assign wrDone = psel && penable && pready && pwrite;

  // ==========================================================================
  // Loss detection
  assign rxLimit = loss_criteria_sel ? LOSS_CNT_W'(LINE_SIGNAL_LOSS_N_ALT) : LOSS_CNT_W'(LINE_SIGNAL_LOSS_N_STD); // [R3] [R2]

  // Transmit period by code
  always_comb begin
    case (lossCfg[LD_TX_PER_LSB +: 2])
      2'b00:   txLimit = TX_PERIOD_SHORT; // [R9]
      2'b01:   txLimit = TX_PERIOD_MID;   // [R9]
      default: txLimit = TX_PERIOD_LONG;  // [R9]
    endcase
  end

  lec_loss_timer u_rxLoss (
    .sys_clk      (sys_clk),
    .arst_n       (arst_n),
    .intervalTick (rxIntervalTick),
    .above        (rxAbove),
    .limit        (rxLimit),
    .lost         (line_signal_loss)
  );

  lec_loss_timer u_txLoss (
    .sys_clk      (sys_clk),
    .arst_n       (arst_n),
    .intervalTick (txIntervalTick),
    .above        (txAbove),
    .limit        (txLimit),
    .lost         (transmit_signal_loss)
  );

  // ==========================================================================
  // Error counter
  lec_error_counter #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_errCnt (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .source      (cntSrc),
    .autoMode    (cntMode),
    .manualLatch (manualLatch),
    .lineViol    (line_bipolar_violation),
    .lineExz     (line_excess_zeros),
    .sysViol     (system_bipolar_violation),
    .sysExz      (system_excess_zeros),
    .patErr      (patternError),
    .heldCount   (heldCount),
    .latched     (countLatched)
  );

  // ==========================================================================
  // Register file, insertion and event logic
  always_comb begin
    next_gainCfg         = gainCfg;
    next_lossCfg         = lossCfg;
    next_exzRule         = exzRule;
    next_violPend        = violPend;
    next_berrPend        = berrPend;
    next_cntSrc          = cntSrc;
    next_cntMode         = cntMode;
    next_latchReq        = latchReq;
    next_evMask          = evMask;
    next_evStatus        = evStatus;
    next_insertViolation = 1'b0;
    next_insertBitError  = 1'b0;
    manualLatch          = 1'b0;
    mapped               = 1'b1;
    // Read data for the current address
    case (regIdx)
      IDX_MONITOR_GAIN_CONFIG:        next_prdata = {24'h0000_00, 6'h00, gainCfg[1:0]};
      IDX_LOSS_DETECT_CONFIG:         next_prdata = {24'h0000_00, lossCfg};
      IDX_ERROR_COUNT_INSERT_CONTROL: next_prdata = {24'h0000_00, exzRule, violPend, berrPend,
                                                     cntSrc, cntMode, latchReq}; // [R16]
      IDX_EVENT_STATUS:               next_prdata = {27'h000_0000, evStatus};
      IDX_EVENT_MASK:                 next_prdata = {27'h000_0000, evMask};
      IDX_ERROR_COUNT_HIGH:           next_prdata = {24'h0000_00, heldCount[15:8]};
      IDX_ERROR_COUNT_LOW:            next_prdata = {24'h0000_00, heldCount[7:0]};
      IDX_LINK_STATE:                 next_prdata = {28'h000_0000, seSync2, monSync2,
                                                     transmit_signal_loss, line_signal_loss};
      default: begin
        next_prdata = 32'h0000_0000;
        mapped      = 1'b0;
      end
    endcase
    // Answer one cycle into the access phase
    next_pready  = psel && penable && !pready;
    next_pslverr = next_pready && !mapped;
    if (!next_pready) begin
      next_prdata = prdata;
    end
    // Insertion completes on the datapath slot
    if (violPend && txMarkSlot) begin
      next_violPend        = 1'b0; // [R11]
      next_insertViolation = 1'b1; // [R11]
    end
    if (berrPend && patternBitSlot) begin
      next_berrPend       = 1'b0; // [R12]
      next_insertBitError = 1'b1; // [R12]
    end
    // Software writes
    if (wrDone) begin
      case (regIdx)
        IDX_MONITOR_GAIN_CONFIG: next_gainCfg = {6'h00, wByte[1:0]}; // [R1]
        IDX_LOSS_DETECT_CONFIG:  next_lossCfg = wByte; // [R2] [R4] [R5] [R7] [R8] [R9]
        IDX_ERROR_COUNT_INSERT_CONTROL: begin
          next_exzRule  = wByte[EC_EXZ_RULE]; // [R10]
          next_cntSrc   = wByte[EC_SRC_LSB +: 3]; // [R13]
          next_cntMode  = wByte[EC_MODE]; // [R14]
          next_latchReq = wByte[EC_LATCH];
          manualLatch   = wByte[EC_LATCH] && !latchReq; // [R15]
          if (wByte[EC_VIOL_INS]) begin
            next_violPend = 1'b1; // [R11] [R16]
          end
          if (wByte[EC_BERR_INS] && !berrPend) begin
            next_berrPend = 1'b1; // [R12] [R16]
          end
        end
        IDX_EVENT_MASK:   next_evMask   = wByte[EV_WIDTH-1:0];
        IDX_EVENT_STATUS: next_evStatus = evStatus & ~wByte[EV_WIDTH-1:0];
        default: ;
      endcase
    end
    // Sticky events, set wins over clear
    evSet               = '0;
    evSet[EV_LINE_LOSS] = line_signal_loss && !lineLossPrev;
    evSet[EV_TX_LOSS]   = transmit_signal_loss && !txLossPrev; // [R6]
    evSet[EV_VIOL_DONE] = violPend && txMarkSlot;
    evSet[EV_BERR_DONE] = berrPend && patternBitSlot;
    evSet[EV_LATCHED]   = countLatched;
    next_evStatus       = next_evStatus | evSet;
    next_irq            = |(next_evStatus & next_evMask);
  end

  // State registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gainCfg         <= RST_MONITOR_GAIN_CONFIG;
      lossCfg         <= RST_LOSS_DETECT_CONFIG;
      exzRule         <= RST_ERROR_COUNT_CONTROL[EC_EXZ_RULE];
      violPend        <= 1'b0;
      berrPend        <= 1'b0;
      cntSrc          <= RST_ERROR_COUNT_CONTROL[EC_SRC_LSB +: 3];
      cntMode         <= RST_ERROR_COUNT_CONTROL[EC_MODE];
      latchReq        <= RST_ERROR_COUNT_CONTROL[EC_LATCH];
      evStatus        <= '0;
      evMask          <= '0;
      lineLossPrev    <= 1'b0;
      txLossPrev      <= 1'b0;
      prdata          <= '0;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      insertViolation <= 1'b0;
      insertBitError  <= 1'b0;
      irq             <= 1'b0;
    end else begin
      gainCfg         <= next_gainCfg;
      lossCfg         <= next_lossCfg;
      exzRule         <= next_exzRule;
      violPend        <= next_violPend;
      berrPend        <= next_berrPend;
      cntSrc          <= next_cntSrc;
      cntMode         <= next_cntMode;
      latchReq        <= next_latchReq;
      evStatus        <= next_evStatus;
      evMask          <= next_evMask;
      lineLossPrev    <= line_signal_loss;
      txLossPrev      <= transmit_signal_loss;
      prdata          <= next_prdata;
      pready          <= next_pready;
      pslverr         <= next_pslverr;
      insertViolation <= next_insertViolation;
      insertBitError  <= next_insertBitError;
      irq             <= next_irq;
    end
  end

  // ==========================================================================
  // Registered control outputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      monitor_gain_sel     <= '0;
      monitorGainDb        <= '0;
      loss_criteria_sel    <= 1'b0;
      rxThresholdCv        <= '0;
      rxThresholdReserved  <= 1'b0;
      txThresholdCv        <= '0;
      excess_zero_rule_sel <= 1'b0;
    end else begin
      monitor_gain_sel     <= gainCfg[1:0];
      monitorGainDb        <= gainDb(gainCfg[1:0]); // [R1]
      loss_criteria_sel    <= lossCfg[LD_CRITERIA]; // [R2]
      rxThresholdCv        <= rxThrCv(lossCfg[LD_RX_THR_LSB +: 3], monSync2); // [R4] [R5]
      rxThresholdReserved  <= monSync2 && lossCfg[LD_RX_THR_LSB + 2]; // [R5]
      txThresholdCv        <= txThrCv(lossCfg[LD_TX_THR_LSB +: 2], seSync2); // [R7] [R8]
      excess_zero_rule_sel <= exzRule; // [R10]
    end
  end

endmodule
`default_nettype wire

// [test/lec_line_model.sv]
// Line side model: ticks and slots
`timescale 1ns/1ps
`default_nettype none
module lec_line_model (
  // Clock, reset and slot enable
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic slotEn,
  // Strobes toward the block
  output logic      tick,
  output logic      slot
);
  logic [1:0] phase;
  // One pulse interval every four clocks
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) phase <= 2'h0;
    else phase <= phase + 2'h1;
  end
  // Slots follow the ticks only while enabled
  assign tick = (phase == 2'h3);
  assign slot = tick & slotEn;
endmodule
`default_nettype wire

// [test/lec_loss_error_control_asserts.sv]
// Port checker
`timescale 1ns/1ps
`default_nettype none
module lec_loss_error_control_asserts (
  // Watched ports
  input wire logic       sys_clk, arst_n, psel, penable, pready, pslverr, rxIntervalTick, rxAbove,
  input wire logic       txIntervalTick, txAbove, txMarkSlot, patternBitSlot, insertViolation,
  input wire logic       insertBitError, line_signal_loss, transmit_signal_loss,
  input wire logic [1:0] monitor_gain_sel,
  input wire logic [7:0] monitorGainDb
);
  // ==========================================================================
  // Expected gain from its code
  wire [7:0] gainExp = monitor_gain_sel[1] ? (monitor_gain_sel[0] ? 8'h20 : 8'h1a) :
                       (monitor_gain_sel[0] ? 8'h14 : 8'h00);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_gain_map: assert property (monitorGainDb == gainExp) else $error("gain mismatch");
  a_rx_clear: assert property (rxIntervalTick && rxAbove |=> !line_signal_loss) else $error("rx kept");
  a_tx_clear: assert property (txIntervalTick && txAbove |=> !transmit_signal_loss) else $error("tx kept");
  a_rx_rise: assert property ($rose(line_signal_loss) |-> $past(rxIntervalTick) && !$past(rxAbove))
    else $error("rx loss early");
  a_viol_slot: assert property (insertViolation |-> $past(txMarkSlot) || $past(txMarkSlot, 2))
    else $error("stray violation");
  a_viol_pulse: assert property (insertViolation |=> !insertViolation) else $error("violation held");
  a_berr_slot: assert property (insertBitError |-> ($past(patternBitSlot) || $past(patternBitSlot, 2)) ##1
    !insertBitError) else $error("bit error misplaced");
  c_loss: cover property ($rose(transmit_signal_loss));
  c_viol: cover property (insertViolation);
  c_err: cover property (pslverr);
endmodule
bind lec_loss_error_control lec_loss_error_control_asserts u_chk (.*);
`default_nettype wire

// [test/tb_top.sv]
// Testbench
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lec_pkg::*;
  logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, above = 1, slotEn = 0, pErr;
  logic lineMonitorMode = 0, singleEndedTx = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [4:0] ev = 0;
  logic [7:0] rd;
  wire [31:0] prdata;
  wire [7:0] monitorGainDb, rxThresholdCv, txThresholdCv;
  wire [1:0] monitor_gain_sel;
  wire pready, pslverr, loss_criteria_sel, rxThresholdReserved, excess_zero_rule_sel, insertViolation;
  wire insertBitError, line_signal_loss, transmit_signal_loss, irq, tick, slot;
  wire [3:0] mon = {insertBitError, insertViolation, transmit_signal_loss, line_signal_loss};
  int num_errors = 0, n_compared = 0;
  localparam logic [9:0] ECR = IDX_ERROR_COUNT_INSERT_CONTROL, LDC = IDX_LOSS_DETECT_CONFIG;
  logic [7:0] rxTab [16] = '{8'h32, 8'h46, 8'h5a, 8'h78, 8'h8c, 8'ha0, 8'hb4, 8'hc8,
                             8'h64, 8'h8c, 8'hb4, 8'hdc, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] txTab [8] = '{8'h78, 8'h5a, 8'h3c, 8'h28, 8'h3d, 8'h30, 8'h20, 8'h18};
  // Block, short counts
  lec_loss_error_control #(.LINE_SIGNAL_LOSS_N_STD(4), .LINE_SIGNAL_LOSS_N_ALT(8), .SEC_CYCLES(100)) u_dut (.*,
    .rxIntervalTick(tick), .txIntervalTick(tick), .txMarkSlot(slot), .patternBitSlot(slot),
    .rxAbove(above), .txAbove(above), .line_bipolar_violation(ev[0]), .line_excess_zeros(ev[1]),
    .system_bipolar_violation(ev[2]), .system_excess_zeros(ev[3]), .patternError(ev[4]));
  lec_line_model u_line (.sys_clk, .arst_n, .slotEn, .tick, .slot);
  // Verdict and end of run
  task automatic close_out();
    $display("Errors %0d of %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Compare and report
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
    int n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      close_out();
    end
    pErr = pslverr;
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait for a status bit, counting ticks
  task automatic waitBit(input int b, output int t);
    t = 0;
    for (int i = 0; i < 400 && mon[b] !== 1'b1; i++) begin
      @(negedge sys_clk);
      if (mon[b] !== 1'b1 && tick === 1'b1) t++;
    end
    if (mon[b] !== 1'b1) begin
      num_errors++;
      close_out();
    end
  endtask
  // Defaults, gain
  task automatic t_defaults();
    logic [7:0] db [4] = '{8'h00, 8'h14, 8'h1a, 8'h20};
    repeat (4) @(negedge sys_clk);
    chk("rx thr", 8'h46, rxThresholdCv);
    chk("tx thr", 8'h5a, txThresholdCv);
    apb(0, LDC, 8'h00);
    chk("loss cfg", 8'h15, rd);
    apb(0, ECR, 8'h00);
    chk("err cfg", 8'h00, rd);
    for (int g = 0; g < 4; g++) begin
      apb(1, IDX_MONITOR_GAIN_CONFIG, {6'h00, g[1:0]});
      apb(0, IDX_MONITOR_GAIN_CONFIG, 8'h00);
      chk("gain", db[g], monitorGainDb);
    end
  endtask
  // Thresholds
  task automatic t_thr();
    for (int m = 0; m < 2; m++) begin
      lineMonitorMode <= m[0];
      singleEndedTx <= m[0];
      for (int c = 0; c < 8; c++) begin
        apb(1, LDC, {1'b0, c[2:0], c[1:0], 2'b01});
        repeat (4) @(negedge sys_clk);
        chk("rx thr", rxTab[m*8+c], rxThresholdCv);
        chk("tx thr", txTab[m*4+c%4], txThresholdCv);
        chk("reserved", 8'(m[0] & c[2]), 8'(rxThresholdReserved));
      end
    end
  endtask
  // Loss periods
  task automatic t_loss();
    int t;
    int exp [6] = '{16, 32, 64, 64, 4, 8};
    for (int i = 0; i < 6; i++) begin
      apb(1, LDC, i < 4 ? {6'h05, i[1:0]} : {i[0], 7'h15});
      above <= 1'b0;
      waitBit(i < 4, t);
      chk("low ticks", 8'(exp[i]), 8'(t));
      chk("criteria", 8'(i == 5), 8'(loss_criteria_sel));
      @(posedge sys_clk);
      above <= 1'b1;
      repeat (8) @(negedge sys_clk);
      chk("loss cleared", 8'h00, 8'(mon[i < 4]));
    end
  endtask
  // Insertions
  task automatic t_insert();
    int t;
    apb(1, IDX_EVENT_MASK, 8'h04);
    apb(1, IDX_EVENT_STATUS, 8'h1f);
    for (int k = 0; k < 2; k++) begin
      apb(1, ECR, k ? 8'h20 : 8'h40);
      apb(0, ECR, 8'h00);
      chk("pending", k ? 8'h20 : 8'h40, rd);
      slotEn <= 1'b1;
      waitBit(2 + k, t);
      @(posedge sys_clk);
      slotEn <= 1'b0;
      apb(0, ECR, 8'h00);
      chk("done", 8'h00, rd);
      chk("irq", 8'(k == 0), 8'(irq));
      apb(1, IDX_EVENT_STATUS, 8'h04);
    end
  endtask
  // Error counting
  task automatic t_count();
    int e [8] = '{0, 1, 1, 2, 1, 1, 2, 1};
    for (int s = 0; s < 8; s++) begin
      apb(1, ECR, {s[0], 2'b00, s[2:0], 2'b00});
      ev <= 5'h1f;
      @(posedge sys_clk);
      ev <= 5'h00;
      apb(1, ECR, {s[0], 2'b00, s[2:0], 2'b01});
      apb(0, IDX_ERROR_COUNT_LOW, 8'h00);
      chk("count", 8'(e[s]), rd);
      chk("exz rule", 8'(s[0]), 8'(excess_zero_rule_sel));
    end
    apb(1, IDX_EVENT_STATUS, 8'h1f);
    apb(1, ECR, 8'h06);
    repeat (110) @(posedge sys_clk);
    apb(0, IDX_EVENT_STATUS, 8'h00);
    chk("auto latch", 8'h10, rd & 8'h10);
    apb(0, 10'h0ff, 8'h00);
    chk("unmapped", 8'h01, 8'(pErr));
  endtask
  // Clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_defaults();
    t_thr();
    t_loss();
    t_insert();
    t_count();
    close_out();
  end
endmodule
`default_nettype wire
